// ==== pbr_device.sv ====
// Supervisor end: button timing, power states, reset, watchdog and status registers
`timescale 1ns/1ps
module pbr_device #(
  parameter int TICK_CYCLES = pbr_pkg::TICK_CYCLES,
  parameter int LONG_PRESS_MS = pbr_pkg::LONG_PRESS_MS,
  parameter bit SOFT_RESET_EN = 1'b1,
  parameter bit FORCE_OFF_EN = 1'b1,
  parameter bit WDOG_EN = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  pbr_if.dev link,
  input wire logic button_input_n,
  input wire logic button_direct,
  output logic rails_en,
  output logic app_core_buck_en,
  output pbr_pkg::pbr_state_e state
);
  import pbr_pkg::*;

  localparam int PRE_W = $clog2(TICK_CYCLES);

  // ****************************************
  // Declarations
  // ****************************************
  pbr_state_e state_ff;
  pbr_state_e nxt_state;
  logic [PRE_W-1:0] pre_ff;
  logic tick;
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_sync_ff;
  logic pressed;
  logic direct;
  logic hold;
  logic sleep_en;
  logic pressed_d_ff;
  logic release_ev;
  logic sleep_en_d_ff;
  logic sleep_fall;
  logic [MS_W-1:0] press_ms_ff;
  logic [MS_W-1:0] st_ms_ff;
  logic [MS_W-1:0] rto_ms_ff;
  logic [MS_W-1:0] wd_ms_ff;
  logic [MS_W-1:0] sw_power_cycle_request_ms_ff;
  logic from_cycle_ff;
  logic mr_ff;
  logic rto_busy_ff;
  logic rto_start;
  logic rto_done;
  logic long_press;
  logic force_off;
  logic wds_ff;
  logic wdp_ff;
  logic arm_ff;
  logic sw_power_cycle_request_ff;
  logic shutdown;
  logic wd_on;
  logic wd_expire;
  logic sw_power_cycle_request_due;
  logic soft_flag_ff;
  logic cycle_flag_ff;
  logic [DATA_W-1:0] mask_ff;
  logic [DATA_W-1:0] status;
  logic wr_ctrl;
  logic rd_status;
  logic [DATA_W-1:0] rdata_ff;
  logic rvalid_ff;
  logic rst_low_ff;
  logic irq_ff;
  logic rails_ff;
  logic buck_ff;

  // Saturating millisecond counter step
  function automatic logic [MS_W-1:0] ms_step(input logic [MS_W-1:0] cur, input logic clr, input logic t);
    if (clr) begin
      ms_step = '0;
    end else if (t && cur != '1) begin
      ms_step = cur + 1'b1;
    end else begin
      ms_step = cur;
    end
  endfunction : ms_step

  // ****************************************
  // Slow timer and pin synchronisers
  // ****************************************
  // slow tick prescaler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= tick ? '0 : pre_ff + 1'b1;
    end
  end
  assign tick = (pre_ff == PRE_W'(TICK_CYCLES - 1));

  // Two-stage sync of button, strap and host levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      pressed_d_ff <= 1'b0;
      sleep_en_d_ff <= 1'b0;
    end else begin
      pin_meta_ff <= {button_direct, ~button_input_n, link.power_hold, link.sleep_rail_enable};
      pin_sync_ff <= pin_meta_ff;
      pressed_d_ff <= pin_sync_ff[2];
      sleep_en_d_ff <= pin_sync_ff[0];
    end
  end
  assign direct = pin_sync_ff[3];
  assign pressed = pin_sync_ff[2];
  assign hold = pin_sync_ff[1];
  assign sleep_en = pin_sync_ff[0];
  assign release_ev = pressed_d_ff & ~pressed;
  // Edge, so a button wake is not undone at once
  assign sleep_fall = sleep_en_d_ff & ~sleep_en;

  // ****************************************
  // Timers
  // ****************************************
  assign long_press = press_ms_ff >= pbr_ticks(LONG_PRESS_MS);
  assign force_off = FORCE_OFF_EN && pressed && press_ms_ff >= pbr_ticks(FORCE_OFF_MS);
  // watchdog runs while enabled and system up
  assign wd_on = WDOG_EN && (wds_ff || wdp_ff) && state_ff == PBR_ON && !rst_low_ff;
  assign wd_expire = wd_on && wd_ms_ff >= pbr_ticks(WDOG_MS);
  // strictly past the delay after the request
  assign sw_power_cycle_request_due = sw_power_cycle_request_ff && sw_power_cycle_request_ms_ff > pbr_ticks(SW_CYCLE_DELAY_MS);

  // Press, state, watchdog and software-cycle timers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      press_ms_ff <= '0;
      st_ms_ff <= '0;
      wd_ms_ff <= '0;
      sw_power_cycle_request_ms_ff <= '0;
    end else begin
      press_ms_ff <= ms_step(press_ms_ff, !pressed, tick);
      st_ms_ff <= ms_step(st_ms_ff, nxt_state != state_ff, tick);
      wd_ms_ff <= ms_step(wd_ms_ff, !wd_on || wd_expire || link.reg_wr || link.reg_rd, tick);
      sw_power_cycle_request_ms_ff <= ms_step(sw_power_cycle_request_ms_ff, !sw_power_cycle_request_ff, tick);
    end
  end

  // ****************************************
  // Manual and watchdog soft reset
  // ****************************************
  // short direct press releases into timeout
  // soft reset when only soft enable set
  assign rto_start = (SOFT_RESET_EN && mr_ff && !pressed && !long_press) || (wd_expire && wds_ff && !wdp_ff);
  assign rto_done = rto_busy_ff && rto_ms_ff >= pbr_ticks(RESET_TIMEOUT_MS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mr_ff <= 1'b0;
      rto_busy_ff <= 1'b0;
      rto_ms_ff <= '0;
    end else begin
      mr_ff <= state_ff == PBR_ON && pressed && direct && !long_press;
      rto_ms_ff <= ms_step(rto_ms_ff, rto_start || !rto_busy_ff, tick);
      if (state_ff != PBR_ON || rto_done) begin
        rto_busy_ff <= 1'b0;
      end else if (rto_start) begin
        rto_busy_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  // armed shutdown request
  assign shutdown = wr_ctrl && link.reg_wdata[CT_REQ_BIT] && arm_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PBR_OFF: begin
        // power-up press time
        // Once per press, so a held button after forced off stays off
        if (pressed && press_ms_ff == pbr_ticks(POWER_ON_PRESS_MS)) begin
          nxt_state = PBR_BOOT;
        end
      end
      PBR_BOOT: begin
        // hold missing at release ends boot
        if (force_off || (release_ev && !hold && !from_cycle_ff)) begin
          nxt_state = PBR_OFF;
        end else if (!pressed && hold && st_ms_ff >= pbr_ticks(RESET_TIMEOUT_MS)) begin
          nxt_state = PBR_ON;
        end else if (from_cycle_ff && !pressed && st_ms_ff >= pbr_ticks(BOOT_HOLD_WAIT_MS)) begin
          nxt_state = PBR_OFF;
        end
      end
      PBR_ON: begin
        if (force_off || !hold || shutdown) begin
          nxt_state = PBR_OFF;
        end else if ((mr_ff && long_press) || (wd_expire && wdp_ff) || sw_power_cycle_request_due) begin
          nxt_state = PBR_CYCLE;
        end else if (sleep_fall && !rst_low_ff) begin
          nxt_state = PBR_SLEEP;
        end
      end
      PBR_SLEEP: begin
        if (force_off || !hold) begin
          nxt_state = PBR_OFF;
        end else if (pressed || sleep_en) begin
          nxt_state = PBR_ON;
        end
      end
      PBR_CYCLE: begin
        if (st_ms_ff >= pbr_ticks(CYCLE_OFF_MS)) begin
          nxt_state = PBR_BOOT;
        end
      end
      default: begin
        nxt_state = PBR_OFF;
      end
    endcase
  end

  // State, boot origin and output levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= PBR_OFF;
      from_cycle_ff <= 1'b0;
      rails_ff <= 1'b0;
      buck_ff <= 1'b0;
      rst_low_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state == PBR_BOOT && state_ff != PBR_BOOT) begin
        from_cycle_ff <= state_ff == PBR_CYCLE;
      end
      rails_ff <= nxt_state != PBR_OFF && nxt_state != PBR_CYCLE;
      buck_ff <= nxt_state == PBR_BOOT || nxt_state == PBR_ON;
      // low through startup timeout and manual reset
      rst_low_ff <= (nxt_state != PBR_ON && nxt_state != PBR_SLEEP
                     && !(nxt_state == PBR_BOOT && state_ff == PBR_BOOT && st_ms_ff >= pbr_ticks(RESET_TIMEOUT_MS)))
                    || (nxt_state == PBR_ON && ((SOFT_RESET_EN && mr_ff) || rto_busy_ff || rto_start)
                        && !rto_done);
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  assign wr_ctrl = link.reg_wr && link.reg_addr == ADDR_CTRL;
  assign rd_status = link.reg_rd && link.reg_addr == ADDR_STATUS;

  // Control bits from host writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wds_ff <= 1'b0;
      wdp_ff <= 1'b0;
      arm_ff <= 1'b0;
      sw_power_cycle_request_ff <= 1'b0;
      mask_ff <= MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        wds_ff <= link.reg_wdata[CT_WDS_BIT];
        wdp_ff <= link.reg_wdata[CT_WDP_BIT];
        arm_ff <= link.reg_wdata[CT_ARM_BIT] && !link.reg_wdata[CT_REQ_BIT];
      end else if (state_ff == PBR_OFF) begin
        arm_ff <= 1'b0;
      end
      if (sw_power_cycle_request_due || state_ff != PBR_ON) begin
        sw_power_cycle_request_ff <= 1'b0;
      end else if (wr_ctrl && link.reg_wdata[CT_SW_POWER_CYCLE_REQUEST_BIT]) begin
        sw_power_cycle_request_ff <= 1'b1;
      end
      // mask cleared by reset, host unmasks
      if (link.reg_wr && link.reg_addr == ADDR_MASK) begin
        mask_ff <= link.reg_wdata;
      end
    end
  end

  // Sticky status flags, a new event beats the read clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_flag_ff <= 1'b0;
      cycle_flag_ff <= 1'b0;
    end else begin
      // cleared by the read that returns it
      soft_flag_ff <= rto_done || (soft_flag_ff && !rd_status);
      cycle_flag_ff <= (state_ff == PBR_CYCLE && nxt_state == PBR_BOOT) || (cycle_flag_ff && !rd_status);
    end
  end

  always_comb begin
    status = '0;
    status[ST_SOFT_BIT] = soft_flag_ff;
    status[ST_CYCLE_BIT] = cycle_flag_ff;
    status[ST_BUTTON_BIT] = pressed;
  end

  // Read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= link.reg_rd;
      unique case (link.reg_addr)
        ADDR_STATUS: rdata_ff <= status;
        ADDR_CTRL: rdata_ff <= DATA_W'({sw_power_cycle_request_ff, 1'b0, arm_ff, wdp_ff, wds_ff});
        ADDR_MASK: rdata_ff <= mask_ff;
        default: rdata_ff <= '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status & mask_ff);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.system_reset_out_n_o = 1'b0;
  assign link.system_reset_out_n_oe = rst_low_ff;
  assign link.button_status_out_n_o = 1'b0;
  assign link.button_status_out_n_oe = pressed;
  assign link.interrupt_request_out_n_o = 1'b0;
  assign link.interrupt_request_out_n_oe = irq_ff;
  assign link.reg_rdata = rdata_ff;
  assign link.reg_rvalid = rvalid_ff;
  assign rails_en = rails_ff;
  assign app_core_buck_en = buck_ff;
  assign state = state_ff;

endmodule : pbr_device

// ==== pbr_pkg.sv ====
// Shared constants, register map and state codes for the push-button power and reset supervisor
package pbr_pkg;

  // ****************************************
  // Clock and slow timer
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int MS_W = 14;

  // ****************************************
  // Times in milliseconds
  // ****************************************
  localparam int POWER_ON_PRESS_MS = 32;
  localparam int LONG_PRESS_MS = 4000;
  localparam int LONG_PRESS_ALT_MS = 10000;
  localparam int FORCE_OFF_MS = 10000;
  localparam int WDOG_MS = 4000;
  localparam int SW_CYCLE_DELAY_MS = 8;
  localparam int RESET_TIMEOUT_MS = 64;
  localparam int CYCLE_OFF_MS = 100;
  localparam int BOOT_HOLD_WAIT_MS = 1000;
  localparam int HOST_WDOG_DELAY_MS = 1000;

  // ****************************************
  // Register port and map
  // ****************************************
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 2'h2;
  localparam int ST_SOFT_BIT = 0;
  localparam int ST_CYCLE_BIT = 1;
  localparam int ST_BUTTON_BIT = 2;
  localparam int CT_WDS_BIT = 0;
  localparam int CT_WDP_BIT = 1;
  localparam int CT_ARM_BIT = 2;
  localparam int CT_REQ_BIT = 3;
  localparam int CT_SW_POWER_CYCLE_REQUEST_BIT = 4;
  localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;

  // ****************************************
  // State codes
  // ****************************************
  typedef enum logic [2:0] {
    PBR_OFF = 3'h0,
    PBR_BOOT = 3'h1,
    PBR_ON = 3'h3,
    PBR_SLEEP = 3'h2,
    PBR_CYCLE = 3'h7
  } pbr_state_e;

  // Milliseconds to slow timer ticks, rounded up
  function automatic logic [MS_W-1:0] pbr_ticks(input int ms);
    pbr_ticks = MS_W'((ms * 1000 + TICK_US - 1) / TICK_US);
  endfunction : pbr_ticks

endpackage : pbr_pkg

// ==== pbr_if.sv ====
// Pins and register port between the supervisor and the host processor
`timescale 1ns/1ps
interface pbr_if;
  import pbr_pkg::*;

  // Open-drain drivers and their resolved, pulled-up levels
  logic system_reset_out_n_o;
  logic system_reset_out_n_oe;
  logic button_status_out_n_o;
  logic button_status_out_n_oe;
  logic interrupt_request_out_n_o;
  logic interrupt_request_out_n_oe;
  logic system_reset_out_n;
  logic button_status_out_n;
  logic interrupt_request_out_n;
  // Host driven levels
  logic power_hold;
  logic sleep_rail_enable;
  // Register port behind the serial slave
  logic reg_wr;
  logic reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_rvalid;

  // Wire levels with pull-ups
  assign system_reset_out_n = system_reset_out_n_oe ? system_reset_out_n_o : 1'b1;
  assign button_status_out_n = button_status_out_n_oe ? button_status_out_n_o : 1'b1;
  assign interrupt_request_out_n = interrupt_request_out_n_oe ? interrupt_request_out_n_o : 1'b1;

  modport dev (
    output system_reset_out_n_o, system_reset_out_n_oe, button_status_out_n_o, button_status_out_n_oe,
    output interrupt_request_out_n_o, interrupt_request_out_n_oe, reg_rdata, reg_rvalid,
    input power_hold, sleep_rail_enable, reg_wr, reg_rd, reg_addr, reg_wdata
  );

  modport host (
    input system_reset_out_n, button_status_out_n, interrupt_request_out_n, reg_rdata, reg_rvalid,
    output power_hold, sleep_rail_enable, reg_wr, reg_rd, reg_addr, reg_wdata
  );
endinterface : pbr_if

// ==== pbr_host.sv ====
// Host processor end: power-hold, sleep-enable and register writes toward the supervisor
`timescale 1ns/1ps
module pbr_host #(
  parameter int TICK_CYCLES = pbr_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  pbr_if.host link,
  input wire logic cmd_shutdown,
  input wire logic cmd_drop_hold,
  input wire logic cmd_sleep,
  input wire logic cmd_wake,
  input wire logic cmd_mask,
  input wire logic [pbr_pkg::DATA_W-1:0] mask_data,
  input wire logic cmd_read,
  output logic [pbr_pkg::DATA_W-1:0] status_data,
  output logic status_valid,
  output logic reset_seen,
  output logic button_seen,
  output logic irq_seen,
  output logic busy
);
  import pbr_pkg::*;

  localparam int PRE_W = $clog2(TICK_CYCLES);

  typedef enum logic [2:0] {
    PBH_IDLE = 3'h0,
    PBH_WAIT = 3'h1,
    PBH_WDS_SET = 3'h3,
    PBH_WDS_CLR = 3'h2,
    PBH_ARM = 3'h6,
    PBH_REQ = 3'h7,
    PBH_MASK = 3'h5,
    PBH_READ = 3'h4
  } pbh_state_e;

  pbh_state_e state_ff;
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic rst_low_d_ff;
  logic rel_ev;
  logic hold_ff;
  logic sleep_en_ff;
  logic [DATA_W-1:0] mask_ff;
  logic [PRE_W-1:0] pre_ff;
  logic [MS_W-1:0] wait_ms_ff;
  logic [DATA_W-1:0] status_ff;
  logic status_valid_ff;

  // Two-stage sync of the open-drain pin levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      rst_low_d_ff <= 1'b0; // Same as synced reset value, no false release
    end else begin
      meta_ff <= {~link.system_reset_out_n, ~link.button_status_out_n, ~link.interrupt_request_out_n};
      sync_ff <= meta_ff;
      rst_low_d_ff <= sync_ff[2];
    end
  end
  assign rel_ev = rst_low_d_ff && !sync_ff[2];

  // take hold as soon as reset releases
  // hold kept through sleep and resets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_ff <= 1'b0;
      sleep_en_ff <= 1'b1;
      mask_ff <= '0;
    end else begin
      if (cmd_drop_hold) begin
        hold_ff <= 1'b0;
      end else if (rel_ev) begin
        hold_ff <= 1'b1;
      end
      if (cmd_sleep) begin
        sleep_en_ff <= 1'b0;
      end else if (cmd_wake || rel_ev) begin
        sleep_en_ff <= 1'b1;
      end
      if (cmd_mask && state_ff == PBH_IDLE) begin
        mask_ff <= mask_data;
      end
    end
  end

  // Delay timer for the post-reset watchdog pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_ff <= '0;
      wait_ms_ff <= '0;
    end else begin
      pre_ff <= (pre_ff == PRE_W'(TICK_CYCLES - 1)) ? '0 : pre_ff + 1'b1;
      if (state_ff != PBH_WAIT) begin
        wait_ms_ff <= '0;
      end else if (pre_ff == PRE_W'(TICK_CYCLES - 1)) begin
        wait_ms_ff <= wait_ms_ff + 1'b1;
      end
    end
  end

  // One register access per state other than PBH_IDLE and PBH_WAIT
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= PBH_IDLE;
    end else begin
      unique case (state_ff)
        PBH_IDLE: begin
          if (rel_ev) begin
            state_ff <= PBH_WAIT;
          end else if (cmd_shutdown) begin
            state_ff <= PBH_ARM;
          end else if (cmd_mask) begin
            state_ff <= PBH_MASK;
          end else if (cmd_read) begin
            state_ff <= PBH_READ;
          end
        end
        PBH_WAIT: state_ff <= (wait_ms_ff >= pbr_ticks(HOST_WDOG_DELAY_MS)) ? PBH_WDS_SET : PBH_WAIT;
        PBH_WDS_SET: state_ff <= PBH_WDS_CLR;
        PBH_ARM: state_ff <= PBH_REQ;
        PBH_WDS_CLR, PBH_REQ, PBH_MASK, PBH_READ: state_ff <= PBH_IDLE;
      endcase
    end
  end

  // Captured status read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_ff <= '0;
      status_valid_ff <= 1'b0;
    end else begin
      status_valid_ff <= link.reg_rvalid;
      if (link.reg_rvalid) begin
        status_ff <= link.reg_rdata;
      end
    end
  end

  assign link.reg_wr = state_ff inside {PBH_WDS_SET, PBH_WDS_CLR, PBH_ARM, PBH_REQ, PBH_MASK};
  assign link.reg_rd = state_ff == PBH_READ;
  assign link.reg_addr = (state_ff == PBH_MASK) ? ADDR_MASK : (state_ff == PBH_READ) ? ADDR_STATUS : ADDR_CTRL;
  always_comb begin
    link.reg_wdata = '0;
    unique case (state_ff)
      PBH_WDS_SET: link.reg_wdata[CT_WDS_BIT] = 1'b1;
      PBH_ARM: link.reg_wdata[CT_ARM_BIT] = 1'b1;
      PBH_REQ: link.reg_wdata[CT_REQ_BIT] = 1'b1;
      PBH_MASK: link.reg_wdata = mask_ff;
      default: link.reg_wdata = '0;
    endcase
  end
  assign link.power_hold = hold_ff;
  assign link.sleep_rail_enable = sleep_en_ff;
  assign status_data = status_ff;
  assign status_valid = status_valid_ff;
  assign reset_seen = sync_ff[2];
  assign button_seen = sync_ff[1];
  assign irq_seen = sync_ff[0];
  assign busy = state_ff != PBH_IDLE;

endmodule : pbr_host

// ==== pbr_sva.sv ====
// Checker of the pin and register traffic between supervisor and host
`timescale 1ns/1ps
module pbr_sva #(
  parameter int TICK_CYCLES = pbr_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic system_reset_out_n_o,
  input wire logic interrupt_request_out_n_o,
  input wire logic interrupt_request_out_n_oe,
  input wire logic system_reset_out_n,
  input wire logic power_hold,
  input wire logic sleep_rail_enable,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pbr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pbr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [pbr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  import pbr_pkg::*;
  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);
  logic [DATA_W-1:0] mask_ff;
  logic rd_status_ff;
  int low_ff;
  // Mirror of the interrupt mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_ff <= MASK_RESET;
    end else if (reg_wr && reg_addr == ADDR_MASK) begin
      mask_ff <= reg_wdata;
    end
  end
  // Status read in flight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_status_ff <= 1'b0;
    end else begin
      rd_status_ff <= reg_rd && reg_addr == ADDR_STATUS;
    end
  end
  // Length of the current reset pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_ff <= 0;
    end else begin
      low_ff <= system_reset_out_n ? 0 : low_ff + 1;
    end
  end
  // ****
  // Sequences
  // ****
  sequence s_arm;
    reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CT_ARM_BIT];
  endsequence
  sequence s_req;
    reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CT_REQ_BIT];
  endsequence
  sequence s_wd_set;
    reg_wr && reg_addr == ADDR_CTRL && reg_wdata == 8'h01;
  endsequence
  sequence s_wd_clr;
    reg_wr && reg_addr == ADDR_CTRL && reg_wdata == 8'h00;
  endsequence
  // ****
  // Assertions
  // ****
  a_rvalid_exact: assert property (reg_rvalid == $past(reg_rd))
    else $error("rvalid not one cycle after read");
  a_od_low_only: assert property (!system_reset_out_n_o && !interrupt_request_out_n_o)
    else $error("open drain pin driven high");
  a_irq_masked_reset: assert property (mask_ff == 8'h00 && $past(mask_ff) == 8'h00 |-> !interrupt_request_out_n_oe)
    else $error("irq with all sources masked");
  a_irq_follows_mask: assert property (reg_rvalid && rd_status_ff |->
    interrupt_request_out_n_oe == |(reg_rdata & $past(mask_ff)))
    else $error("irq differs from masked status");
  a_shutdown_off: assert property (s_arm ##[1:4] s_req |-> ##[1:2] !system_reset_out_n)
    else $error("no power off after shutdown request");
  a_hold_drop_off: assert property ($fell(power_hold) |-> ##[1:4] !system_reset_out_n)
    else $error("no power off after hold drop");
  a_reset_timeout: assert property ($rose(system_reset_out_n) |-> low_ff >= (RESET_TIMEOUT_MS - 1) * TICK_CYCLES)
    else $error("reset released before timeout");
  a_sleep_hold: assert property (!sleep_rail_enable |-> power_hold)
    else $error("hold low during sleep");
  a_wdog_pulse: assert property (s_wd_set |-> ##[1:8] s_wd_clr)
    else $error("watchdog enable not cleared");
endmodule : pbr_sva

// ==== tb_top.sv ====
// Testbench driving the user sides of the supervisor and host ends
`timescale 1ns/1ps
module tb_top;
  import pbr_pkg::*;
  localparam int TC = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic btn_n = 1'b1;
  logic direct = 1'b0;
  logic [5:0] cmd = 6'h00;
  logic [DATA_W-1:0] md = 8'h00;
  logic [DATA_W-1:0] sd;
  logic sv, rs, bs, irq, busy, rails, buck;
  pbr_state_e st;
  int n_fail = 0;
  int comparisons = 0;
  pbr_if link ();
  pbr_device #(.TICK_CYCLES(TC), .LONG_PRESS_MS(100)) pbr_device_inst (.clk(clk), .rst(rst), .link(link),
    .button_input_n(btn_n), .button_direct(direct), .rails_en(rails), .app_core_buck_en(buck), .state(st));
  pbr_host #(.TICK_CYCLES(TC)) pbr_host_inst (.clk(clk), .rst(rst), .link(link), .cmd_shutdown(cmd[0]),
    .cmd_drop_hold(cmd[1]), .cmd_sleep(cmd[2]), .cmd_wake(cmd[3]), .cmd_mask(cmd[4]), .mask_data(md),
    .cmd_read(cmd[5]), .status_data(sd), .status_valid(sv), .reset_seen(rs), .button_seen(bs), .irq_seen(irq),
    .busy(busy));
  pbr_sva #(.TICK_CYCLES(TC)) pbr_sva_inst (.clk(clk), .rst(rst), .system_reset_out_n_o(link.system_reset_out_n_o),
    .interrupt_request_out_n_o(link.interrupt_request_out_n_o),
    .interrupt_request_out_n_oe(link.interrupt_request_out_n_oe), .system_reset_out_n(link.system_reset_out_n),
    .power_hold(link.power_hold), .sleep_rail_enable(link.sleep_rail_enable), .reg_wr(link.reg_wr),
    .reg_rd(link.reg_rd), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .reg_rvalid(link.reg_rvalid));
  // Clock at 20 MHz
  always #25 clk = ~clk;
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    @(negedge clk);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Button level and kind, held for a number of ticks
  task automatic btn(input logic lvl, input logic d, input int ticks);
    @(posedge clk);
    btn_n <= lvl;
    direct <= d;
    repeat (ticks * TC) @(posedge clk);
  endtask : btn
  // One cycle host command once the host is idle
  task automatic send(input int b, input logic [7:0] m);
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 9000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 9000) begin
      n_fail++;
      $display("[ERR] busy expected 0 seen 1");
    end
    @(posedge clk);
    cmd[b] <= 1'b1;
    md <= m;
    @(posedge clk);
    cmd[b] <= 1'b0;
  endtask : send
  task automatic rd(input logic [1:0] exp);
    int k;
    send(5, 8'h00);
    k = 0;
    while (sv !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20) begin
      n_fail++;
      $display("[ERR] status_valid expected 1 seen 0");
    end
    chk("status", {6'h00, exp}, {6'h00, sd[1:0]});
  endtask : rd
  task automatic power_up;
    btn(1'b0, 1'b0, 28);
    chk("state", PBR_OFF, st);
    chk("status_pin", 8'h00, link.button_status_out_n);
    chk("button_seen", 8'h01, bs);
    btn(1'b0, 1'b0, 10);
    chk("state", PBR_BOOT, st);
    btn(1'b0, 1'b0, 80);
    btn(1'b1, 1'b0, 10);
    chk("status_pin", 8'h01, link.button_status_out_n);
    chk("state", PBR_ON, st);
  endtask : power_up
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    btn(1'b0, 1'b0, 40);
    btn(1'b1, 1'b0, 10);
    chk("state", PBR_OFF, st);
    power_up();
    $display("test power_up done");
    btn(1'b0, 1'b1, 10);
    chk("reset_seen", 8'h01, rs);
    btn(1'b1, 1'b0, 40);
    chk("reset_seen", 8'h01, rs);
    btn(1'b1, 1'b0, 40);
    chk("reset_seen", 8'h00, rs);
    chk("irq_seen", 8'h00, irq);
    send(4, 8'h01);
    btn(1'b1, 1'b0, 3);
    chk("irq_seen", 8'h01, irq);
    rd(2'b01);
    btn(1'b1, 1'b0, 3);
    chk("irq_seen", 8'h00, irq);
    rd(2'b00);
    $display("test soft_reset done");
    btn(1'b0, 1'b1, 110);
    chk("state", PBR_CYCLE, st);
    chk("rails", 8'h00, rails);
    btn(1'b1, 1'b0, 300);
    chk("state", PBR_ON, st);
    rd(2'b10);
    $display("test power_cycle done");
    send(2, 8'h00);
    btn(1'b1, 1'b0, 20);
    chk("state", PBR_SLEEP, st);
    chk("buck", 8'h00, buck);
    send(3, 8'h00);
    btn(1'b1, 1'b0, 10);
    chk("buck", 8'h01, buck);
    send(2, 8'h00);
    btn(1'b1, 1'b0, 20);
    btn(1'b0, 1'b0, 5);
    chk("state", PBR_ON, st);
    btn(1'b1, 1'b0, 2);
    send(3, 8'h00);
    btn(1'b1, 1'b0, 10);
    $display("test sleep done");
    btn(1'b0, 1'b0, 10004);
    chk("state", PBR_OFF, st);
    btn(1'b1, 1'b0, 10);
    power_up();
    send(0, 8'h00);
    btn(1'b1, 1'b0, 3);
    chk("rails", 8'h00, rails);
    power_up();
    send(1, 8'h00);
    btn(1'b1, 1'b0, 5);
    chk("state", PBR_OFF, st);
    $display("test power_off done");
    conclude();
  end
  // Watchdog against a hang
  initial begin
    #(60000 * 50);
    n_fail++;
    $display("[ERR] run expected done seen timeout");
    conclude();
  end
endmodule : tb_top
